// ### hw/rip_pkg.sv
// Package for the interrupt shaping and prescaler control block of the RTC.
// Assumes a single 200 MHz system clock; all users reference names as rip_pkg::name.
package rip_pkg;

	// ------------------------------------------------------------------
	// Register offsets and widths
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W          = 4;
	localparam int unsigned DATA_W          = 8;
	localparam logic [3:0]  OFS_CONTROL_1   = 4'h0;
	localparam logic [3:0]  OFS_CONTROL_2   = 4'h1;
	localparam logic [3:0]  OFS_PIN_OUT_SEL = 4'hD;
	localparam logic [3:0]  OFS_TIMER_CTRL  = 4'hE;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int unsigned BIT_EXT_TB      = 7;
	localparam int unsigned BIT_STOP        = 5;
	localparam int unsigned BIT_MIN_EN      = 7;
	localparam int unsigned BIT_SEC_EN      = 6;
	localparam int unsigned BIT_MS_FLAG     = 5;
	localparam int unsigned BIT_PULSE_SEL   = 4;
	localparam int unsigned BIT_ALARM_FLAG  = 3;
	localparam int unsigned BIT_CD_FLAG     = 2;
	localparam int unsigned BIT_ALARM_EN    = 1;
	localparam int unsigned BIT_CD_EN       = 0;
	localparam int unsigned BIT_TIMER_RUN   = 7;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_CONTROL_1   = 8'h00;
	localparam logic [7:0] RST_CONTROL_2   = 8'h00;
	localparam logic [2:0] RST_PIN_OUT_SEL = 3'h0;
	localparam logic [1:0] RST_TIMER_SRC   = 2'h3;

	// ------------------------------------------------------------------
	// Prescaler and pulse timing, counted in oscillator periods
	// ------------------------------------------------------------------
	localparam int unsigned PRE_W          = 15;
	localparam int unsigned PRE_LOW_STAGES = 2;
	localparam int unsigned PRE_TEST_STAGES = 6;
	localparam int unsigned OSC_HZ         = 32768;
	localparam int unsigned PW_W           = 10;
	localparam logic [9:0] PW_1_64    = 10'(OSC_HZ / 64);
	localparam logic [9:0] PW_1_128   = 10'(OSC_HZ / 128);
	localparam logic [9:0] PW_1_4096  = 10'(OSC_HZ / 4096);
	localparam logic [9:0] PW_1_8192  = 10'(OSC_HZ / 8192);
	localparam logic [1:0] SRC_4096HZ = 2'h0;
	localparam logic [1:0] SRC_64HZ   = 2'h1;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rip_bus_req_t;

	typedef enum logic [1:0] {
		PS_IDLE   = 2'b01,
		PS_ACTIVE = 2'b10
	} rip_pulse_state_t;

endpackage : rip_pkg

// ### hw/rip_ctrl.sv
// Interrupt output shaping and prescaler control for a crystal real-time clock.
// Assumes the oscillator level and all pins are already synchronous to ref_clk.
`timescale 1ns/1ps

module rip_ctrl #(
	parameter int unsigned PRE_W = rip_pkg::PRE_W
) (
	input  wire logic                 ref_clk,
	input  wire logic                 reset_n,
	input  wire rip_pkg::rip_bus_req_t bus_req,
	output logic [7:0]                bus_rdata,
	input  wire logic                 osc_clk_lvl,
	input  wire logic                 minute_event,
	input  wire logic                 countdown_event,
	input  wire logic                 alarm_event,
	input  wire logic [7:0]           countdown_reload,
	input  wire logic                 clock_output_pin_i,
	output logic                      clock_output_pin_o,
	output logic                      clock_output_pin_oe,
	output logic                      int_n_o,
	output logic                      int_n_oe,
	output logic                      time_tick
);

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	logic             external_timebase_test_ff;
	logic             stop_ff;
	logic             minute_int_enable_ff;
	logic             second_int_enable_ff;
	logic             timer_int_pulse_select_ff;
	logic             countdown_int_enable_ff;
	logic             alarm_int_enable_ff;
	logic             minute_second_flag_ff;
	logic             countdown_flag_ff;
	logic             alarm_flag_ff;
	logic [2:0]       pin_sel_ff;
	logic [1:0]       timer_src_ff;
	logic             timer_run_ff;
	logic [7:0]       rdata_ff;
	logic             wr_c1;
	logic             wr_c2;
	logic             nxt_minute_second_flag;
	logic             nxt_countdown_flag;
	logic             nxt_alarm_flag;
	logic [1:0]       flag_set;
	logic [1:0]       flag_next;

	assign wr_c1 = bus_req.wr && (bus_req.addr == rip_pkg::OFS_CONTROL_1);
	assign wr_c2 = bus_req.wr && (bus_req.addr == rip_pkg::OFS_CONTROL_2);

	// Control and configuration bits: plain stores on write.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			external_timebase_test_ff <= rip_pkg::RST_CONTROL_1[rip_pkg::BIT_EXT_TB];
			stop_ff                   <= rip_pkg::RST_CONTROL_1[rip_pkg::BIT_STOP];
			minute_int_enable_ff      <= rip_pkg::RST_CONTROL_2[rip_pkg::BIT_MIN_EN];
			second_int_enable_ff      <= rip_pkg::RST_CONTROL_2[rip_pkg::BIT_SEC_EN];
			timer_int_pulse_select_ff <= rip_pkg::RST_CONTROL_2[rip_pkg::BIT_PULSE_SEL];
			alarm_int_enable_ff       <= rip_pkg::RST_CONTROL_2[rip_pkg::BIT_ALARM_EN];
			countdown_int_enable_ff   <= rip_pkg::RST_CONTROL_2[rip_pkg::BIT_CD_EN];
			pin_sel_ff                <= rip_pkg::RST_PIN_OUT_SEL;
			timer_src_ff              <= rip_pkg::RST_TIMER_SRC;
			timer_run_ff              <= 1'b0;
		end else begin
			if (wr_c1) begin
				external_timebase_test_ff <= bus_req.wdata[rip_pkg::BIT_EXT_TB];
				stop_ff                   <= bus_req.wdata[rip_pkg::BIT_STOP];
			end
			if (wr_c2) begin
				minute_int_enable_ff      <= bus_req.wdata[rip_pkg::BIT_MIN_EN];
				second_int_enable_ff      <= bus_req.wdata[rip_pkg::BIT_SEC_EN];
				timer_int_pulse_select_ff <= bus_req.wdata[rip_pkg::BIT_PULSE_SEL];
				alarm_int_enable_ff       <= bus_req.wdata[rip_pkg::BIT_ALARM_EN];
				countdown_int_enable_ff   <= bus_req.wdata[rip_pkg::BIT_CD_EN];
			end
			if (bus_req.wr && (bus_req.addr == rip_pkg::OFS_PIN_OUT_SEL)) begin
				pin_sel_ff <= bus_req.wdata[2:0];
			end
			if (bus_req.wr && (bus_req.addr == rip_pkg::OFS_TIMER_CTRL)) begin
				timer_src_ff <= bus_req.wdata[1:0];
				timer_run_ff <= bus_req.wdata[rip_pkg::BIT_TIMER_RUN];
			end
		end
	end

	// ------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------
	logic             osc_lvl_ff;
	logic             ext_lvl_ff;
	logic             osc_rise;
	logic             ext_rise;
	logic [PRE_W-1:0] pre_ff;
	logic [PRE_W-1:0] nxt_pre;
	logic             time_tick_ff;
	logic             pre64_lvl_ff;
	logic             tick_64hz;

	// Edge detectors; both inputs are treated as synchronous to ref_clk.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			osc_lvl_ff <= 1'b0;
			ext_lvl_ff <= 1'b0;
		end else begin
			osc_lvl_ff <= osc_clk_lvl;
			ext_lvl_ff <= clock_output_pin_i;
		end
	end

	assign osc_rise = osc_clk_lvl && !osc_lvl_ff;
	assign ext_rise = clock_output_pin_i && !ext_lvl_ff && external_timebase_test_ff;

	// Next prescaler value. The two lowest stages never see stop, so the
	// restart phase after a stop is uncertain by up to one 8.192 kHz cycle.
	always_comb begin
		nxt_pre = pre_ff;
		if (osc_rise) begin
			nxt_pre[rip_pkg::PRE_LOW_STAGES-1:0] =
				pre_ff[rip_pkg::PRE_LOW_STAGES-1:0] + 2'h1;
		end
		if (stop_ff) begin
			nxt_pre[PRE_W-1:rip_pkg::PRE_LOW_STAGES] = '0;
		end else if (external_timebase_test_ff) begin
			// Only the top six stages count test pulses, so the divide chain is 2^6.
			if (ext_rise) begin
				nxt_pre[PRE_W-1:PRE_W-rip_pkg::PRE_TEST_STAGES] =
					pre_ff[PRE_W-1:PRE_W-rip_pkg::PRE_TEST_STAGES] + 6'h01;
			end
		end else if (osc_rise) begin
			nxt_pre = pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
		end
	end

	// Prescaler state and the one-second tick on the top stage rising.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pre_ff       <= '0;
			time_tick_ff <= 1'b0;
		end else begin
			pre_ff       <= nxt_pre;
			time_tick_ff <= nxt_pre[PRE_W-1] && !pre_ff[PRE_W-1];
		end
	end

	assign time_tick = time_tick_ff;

	// Internal 64 Hz clock taken from the stage that toggles every 256 periods.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pre64_lvl_ff <= 1'b0;
		end else begin
			pre64_lvl_ff <= pre_ff[8];
		end
	end

	assign tick_64hz = pre_ff[8] && !pre64_lvl_ff;

	// ------------------------------------------------------------------
	// Clock output pin
	// ------------------------------------------------------------------
	logic pin_out_ff;

	// Fast outputs come from the free-running oscillator and low stages, so
	// stop cannot gate them; in test mode the pin is released as an input.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pin_out_ff <= 1'b0;
		end else begin
			case (pin_sel_ff)
				3'h0:    pin_out_ff <= osc_clk_lvl;
				3'h1:    pin_out_ff <= pre_ff[0];
				3'h2:    pin_out_ff <= pre_ff[1];
				3'h3:    pin_out_ff <= pre_ff[PRE_W-1];
				default: pin_out_ff <= 1'b0;
			endcase
		end
	end

	assign clock_output_pin_o  = pin_out_ff;
	assign clock_output_pin_oe = !external_timebase_test_ff;

	// ------------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------------
	// A reload of zero keeps countdown events from setting the flag.
	assign flag_set[1] = countdown_event && timer_run_ff && (countdown_reload != 8'h00);
	assign flag_set[0] = (minute_event && minute_int_enable_ff) ||
	                     (time_tick_ff && second_int_enable_ff);

	// Writes AND into the flags; a set in the same cycle wins over the clear.
	always_comb begin
		nxt_minute_second_flag = minute_second_flag_ff;
		nxt_countdown_flag     = countdown_flag_ff;
		nxt_alarm_flag         = alarm_flag_ff;
		if (wr_c2) begin
			nxt_minute_second_flag = minute_second_flag_ff &
			                         bus_req.wdata[rip_pkg::BIT_MS_FLAG];
			nxt_countdown_flag     = countdown_flag_ff &
			                         bus_req.wdata[rip_pkg::BIT_CD_FLAG];
			nxt_alarm_flag         = alarm_flag_ff &
			                         bus_req.wdata[rip_pkg::BIT_ALARM_FLAG];
		end
		nxt_minute_second_flag = nxt_minute_second_flag | flag_set[0];
		nxt_countdown_flag     = nxt_countdown_flag | flag_set[1];
		nxt_alarm_flag         = nxt_alarm_flag | alarm_event;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			minute_second_flag_ff <= rip_pkg::RST_CONTROL_2[rip_pkg::BIT_MS_FLAG];
			countdown_flag_ff     <= rip_pkg::RST_CONTROL_2[rip_pkg::BIT_CD_FLAG];
			alarm_flag_ff         <= rip_pkg::RST_CONTROL_2[rip_pkg::BIT_ALARM_FLAG];
		end else begin
			minute_second_flag_ff <= nxt_minute_second_flag;
			countdown_flag_ff     <= nxt_countdown_flag;
			alarm_flag_ff         <= nxt_alarm_flag;
		end
	end

	assign flag_next = {nxt_countdown_flag, nxt_minute_second_flag};

	// ------------------------------------------------------------------
	// Pulse generators: index 0 is minute/second, index 1 is countdown
	// ------------------------------------------------------------------
	logic [1:0]                    pulse_active;
	logic [rip_pkg::PW_W-1:0]      pulse_width [2];

	// Countdown width depends on source clock and on a reload of one.
	always_comb begin
		pulse_width[0] = rip_pkg::PW_1_64;
		case (timer_src_ff)
			rip_pkg::SRC_4096HZ:
				pulse_width[1] = (countdown_reload == 8'h01) ?
					rip_pkg::PW_1_8192 : rip_pkg::PW_1_4096;
			rip_pkg::SRC_64HZ:
				pulse_width[1] = (countdown_reload == 8'h01) ?
					rip_pkg::PW_1_128 : rip_pkg::PW_1_64;
			default:
				pulse_width[1] = rip_pkg::PW_1_64;
		endcase
	end

	generate
		for (genvar gi = 0; gi < 2; gi++) begin : g_pulse
			rip_pkg::rip_pulse_state_t  ps_ff;
			logic [rip_pkg::PW_W-1:0]   cnt_ff;

			// A fresh event restarts the pulse; a cleared flag ends it at once.
			always_ff @(posedge ref_clk) begin
				if (!reset_n) begin
					ps_ff  <= rip_pkg::PS_IDLE;
					cnt_ff <= '0;
				end else begin
					case (ps_ff)
						rip_pkg::PS_IDLE: begin
							if (flag_set[gi]) begin
								ps_ff  <= rip_pkg::PS_ACTIVE;
								cnt_ff <= pulse_width[gi];
							end
						end
						rip_pkg::PS_ACTIVE: begin
							if (flag_set[gi]) begin
								cnt_ff <= pulse_width[gi];
							end else if (!flag_next[gi]) begin
								ps_ff <= rip_pkg::PS_IDLE;
							end else if (osc_rise) begin
								if (cnt_ff == 10'h001) begin
									ps_ff <= rip_pkg::PS_IDLE;
								end
								cnt_ff <= cnt_ff - 10'h001;
							end
						end
						default: ps_ff <= rip_pkg::PS_IDLE;
					endcase
				end
			end

			assign pulse_active[gi] = (ps_ff == rip_pkg::PS_ACTIVE);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------------
	logic ms_int;
	logic cd_int;
	logic al_int;
	logic int_oe_ff;

	// Follow mode tracks flags; both enables low drop the minute/second level.
	assign ms_int = timer_int_pulse_select_ff ? pulse_active[0] :
	                (minute_second_flag_ff &&
	                 (minute_int_enable_ff || second_int_enable_ff));
	assign cd_int = countdown_int_enable_ff &&
	                (timer_int_pulse_select_ff ? pulse_active[1] :
	                 countdown_flag_ff);
	assign al_int = alarm_int_enable_ff && alarm_flag_ff;

	// Registered so the pin never glitches; adds one cycle after the cause.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			int_oe_ff <= 1'b0;
		end else begin
			int_oe_ff <= ms_int || cd_int || al_int;
		end
	end

	assign int_n_o  = 1'b0; // Open drain: only ever pulls low.
	assign int_n_oe = int_oe_ff;

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// Read data stand for exactly the cycle after the strobe; else zero.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rdata_ff <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				rip_pkg::OFS_CONTROL_1:
					rdata_ff <= {external_timebase_test_ff, 1'b0, stop_ff, 5'h00};
				rip_pkg::OFS_CONTROL_2:
					rdata_ff <= {minute_int_enable_ff, second_int_enable_ff,
					             minute_second_flag_ff, timer_int_pulse_select_ff,
					             alarm_flag_ff, countdown_flag_ff,
					             alarm_int_enable_ff, countdown_int_enable_ff};
				rip_pkg::OFS_PIN_OUT_SEL:
					rdata_ff <= {5'h00, pin_sel_ff};
				rip_pkg::OFS_TIMER_CTRL:
					rdata_ff <= {timer_run_ff, 5'h00, timer_src_ff};
				default:
					rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign bus_rdata = rdata_ff;

endmodule : rip_ctrl

// ### dv/rip_ctrl_properties.sv
// Port assertions for the interrupt shaping and prescaler control block.
// Assumes a bind from the testbench top, one clock and a sync active-low reset.
`timescale 1ns/1ps
module rip_ctrl_properties (
	input wire logic                  ref_clk,
	input wire logic                  reset_n,
	input wire rip_pkg::rip_bus_req_t bus_req,
	input wire logic [7:0]            bus_rdata,
	input wire logic                  minute_event,
	input wire logic                  countdown_event,
	input wire logic                  alarm_event,
	input wire logic                  clock_output_pin_oe,
	input wire logic                  int_n_o,
	input wire logic                  int_n_oe,
	input wire logic                  time_tick
);
	// ----
	// Shadow of the control bits
	// ----
	logic [7:0] c1_ff;
	logic [7:0] c2_ff;
	logic       w1;
	logic       en_off;

	// Flags are masked out of the copy because events can set them at any time.
	assign w1 = bus_req.wr && bus_req.addr == 4'h1;
	assign en_off = ~|{c2_ff[7:6], c2_ff[4], c2_ff[1:0]};

	// Copy of written control bits, so gating and read data can be predicted.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			c1_ff <= 8'h00;
			c2_ff <= 8'h00;
		end else if (bus_req.wr) begin
			if (bus_req.addr == 4'h0) c1_ff <= bus_req.wdata;
			if (w1) c2_ff <= bus_req.wdata & 8'hD3;
		end
	end

	// ----
	// Properties
	// ----
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	AST_INT_OPEN_DRAIN: assert property (int_n_o == 1'b0)
		else $error("interrupt pin drives high");
	AST_TEST_PIN: assert property (w1 == 1'b0 && bus_req.wr && bus_req.addr == 4'h0
		&& bus_req.wdata[7] |=> !clock_output_pin_oe) else $error("clock pin not released");
	AST_STOP_NO_TICK: assert property (c1_ff[5] && $past(c1_ff[5]) |-> !time_tick)
		else $error("tick while stopped");
	AST_TICK_ONE: assert property (time_tick |=> !time_tick)
		else $error("tick longer than one cycle");
	AST_CLEAR_ALL: assert property (w1 && bus_req.wdata == 8'h00 && !time_tick
		&& !(alarm_event || minute_event || countdown_event) |=> ##1 !int_n_oe)
		else $error("interrupt held after full clear");
	AST_ALARM_RAISE: assert property (alarm_event && c2_ff[1] && !w1 |=> ##1 int_n_oe)
		else $error("alarm not raised");
	AST_ENABLES_OFF: assert property (en_off && $past(en_off) |-> !int_n_oe)
		else $error("interrupt with all enables off");
	AST_RD_CTRL2: assert property (bus_req.rd && bus_req.addr == 4'h1
		|=> (bus_rdata & 8'hD3) == c2_ff) else $error("control bits read back wrong");

	COV_ALARM: cover property (alarm_event ##2 int_n_oe);
	COV_COUNTDOWN: cover property (countdown_event ##2 int_n_oe);
	COV_TICK: cover property (time_tick);
endmodule : rip_ctrl_properties

// ### dv/rip_host_model.sv
// Host-side model: pull-up on the interrupt line and test clock source on the clock pin.
// Assumes the testbench calls pulses() only while the block has released the pin.
`timescale 1ns/1ps
module rip_host_model (
	input  wire logic ref_clk,
	input  wire logic int_n_o,
	input  wire logic int_n_oe,
	input  wire logic clock_output_pin_o,
	input  wire logic clock_output_pin_oe,
	output logic      int_line,
	output logic      pin_line
);
	logic ext_ff = 1'b0;

	// The pull-up wins whenever the block lets go of the interrupt line.
	assign int_line = int_n_oe ? int_n_o : 1'b1;
	// The block's drive wins; otherwise the test clock sets the pin level.
	assign pin_line = clock_output_pin_oe ? clock_output_pin_o : ext_ff;

	// Bursts of 320 ns high and at least 320 ns low; the pin idles low between bursts.
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk) ext_ff <= 1'b1;
			repeat (64) @(posedge ref_clk);
			ext_ff <= 1'b0;
			repeat (64) @(posedge ref_clk);
		end
	endtask : pulses
endmodule : rip_host_model

// ### dv/rip_ctrl_tb.sv
// Self-checking testbench for the interrupt shaping and prescaler control block.
// Assumes the oscillator is sped up to one period per four clocks to keep runs short.
`timescale 1ns/1ps
module rip_ctrl_tb;
	logic                  ref_clk = 1'b0;
	logic                  reset_n = 1'b0;
	rip_pkg::rip_bus_req_t req = '0;
	logic [1:0]            osc_cnt = 2'h0;
	logic                  minute_event = 1'b0;
	logic                  countdown_event = 1'b0;
	logic                  alarm_event = 1'b0;
	logic [7:0]            reload = 8'h00;
	logic [7:0]            bus_rdata;
	logic                  pin_o, pin_oe, pin_line, int_n_o, int_n_oe, int_line, time_tick;
	logic                  pin_prev;
	int                    n_errors = 0;
	int                    compares = 0;
	int                    n_tick = 0;
	int                    n0;
	logic [7:0]            src [6] = '{8'h80, 8'h80, 8'h81, 8'h81, 8'h82, 8'h83};
	logic [7:0]            nv [6] = '{8'h01, 8'h05, 8'h01, 8'h02, 8'h03, 8'h01};
	int                    wid [6] = '{4, 8, 256, 512, 512, 512};

	// ----
	// Clock, oscillator and instances
	// ----
	always #2.5 ref_clk = ~ref_clk;
	// Oscillator level stands for the crystal, four clocks per period.
	always @(posedge ref_clk) osc_cnt <= osc_cnt + 2'h1;
	// Tick counter; tests compare differences so reset-time history does not matter.
	always @(posedge ref_clk) if (time_tick) n_tick <= n_tick + 1;

	rip_ctrl u_rip_ctrl (
		.ref_clk            (ref_clk),
		.reset_n            (reset_n),
		.bus_req            (req),
		.bus_rdata          (bus_rdata),
		.osc_clk_lvl        (osc_cnt[1]),
		.minute_event       (minute_event),
		.countdown_event    (countdown_event),
		.alarm_event        (alarm_event),
		.countdown_reload   (reload),
		.clock_output_pin_i (pin_line),
		.clock_output_pin_o (pin_o),
		.clock_output_pin_oe(pin_oe),
		.int_n_o            (int_n_o),
		.int_n_oe           (int_n_oe),
		.time_tick          (time_tick)
	);
	rip_host_model u_rip_host_model (
		.ref_clk            (ref_clk),
		.int_n_o            (int_n_o),
		.int_n_oe           (int_n_oe),
		.clock_output_pin_o (pin_o),
		.clock_output_pin_oe(pin_oe),
		.int_line           (int_line),
		.pin_line           (pin_line)
	);

	// ----
	// Tasks
	// ----
	task automatic summarize();
		if (n_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp, input string m);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk1
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk) req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk) req.rd <= 1'b0;
		#1 chk8(bus_rdata, e, "read data");
	endtask : rd
	// One-cycle event pulse; bit 2 minute, bit 1 countdown, bit 0 alarm.
	task automatic ev(input logic [2:0] k);
		@(posedge ref_clk) {minute_event, countdown_event, alarm_event} <= k;
		@(posedge ref_clk) {minute_event, countdown_event, alarm_event} <= 3'h0;
	endtask : ev
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc_wait
	// Width in clocks against osc periods; slack covers osc phase and latency.
	task automatic pulse_len(input int w, input string m);
		int n;
		n = 0;
		cyc_wait(2);
		while (int_line === 1'b0 && n < 3000) begin
			cyc_wait(1);
			n++;
		end
		chk1(n >= 4 * w - 6 && n <= 4 * w + 6, 1'b1, m);
	endtask : pulse_len

	// ----
	// Test sequence
	// ----
	initial begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(4'h1, 8'h00);
		rd(4'hE, 8'h03);
		wr(4'h5, 8'hFF);
		rd(4'h5, 8'h00);
		wr(4'h1, 8'h02);
		ev(3'h1);
		cyc_wait(2);
		chk1(int_line, 1'b0, "alarm raise");
		wr(4'h1, 8'h0A);
		rd(4'h1, 8'h0A);
		wr(4'h1, 8'h02);
		cyc_wait(2);
		chk1(int_line, 1'b1, "alarm release");
		for (int i = 0; i < 6; i++) begin
			wr(4'hE, src[i]);
			wr(4'h1, 8'h11);
			@(posedge ref_clk) reload <= nv[i];
			ev(3'h2);
			pulse_len(wid[i], "countdown width");
		end
		wr(4'h1, 8'h11);
		ev(3'h2);
		cyc_wait(50);
		chk1(int_line, 1'b0, "countdown pulse");
		wr(4'h1, 8'h11);
		cyc_wait(2);
		chk1(int_line, 1'b1, "countdown cut short");
		wr(4'h1, 8'h10);
		ev(3'h2);
		cyc_wait(4);
		chk1(int_line, 1'b1, "countdown masked");
		rd(4'h1, 8'h14);
		wr(4'h1, 8'h11);
		@(posedge ref_clk) reload <= 8'h00;
		ev(3'h2);
		cyc_wait(4);
		chk1(int_line, 1'b1, "zero reload");
		rd(4'h1, 8'h11);
		@(posedge ref_clk) reload <= 8'h02;
		wr(4'h1, 8'h01);
		ev(3'h2);
		cyc_wait(2200);
		chk1(int_line, 1'b0, "countdown level");
		wr(4'h1, 8'h04);
		cyc_wait(2);
		chk1(int_line, 1'b1, "countdown enable off");
		wr(4'h1, 8'h90);
		ev(3'h4);
		pulse_len(512, "minute width");
		wr(4'h1, 8'h90);
		ev(3'h4);
		cyc_wait(50);
		wr(4'h1, 8'h90);
		cyc_wait(2);
		chk1(int_line, 1'b1, "minute cut short");
		wr(4'h1, 8'h80);
		ev(3'h4);
		cyc_wait(2200);
		chk1(int_line, 1'b0, "minute level");
		wr(4'h1, 8'h20);
		cyc_wait(2);
		chk1(int_line, 1'b1, "enables off");
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h20);
		cyc_wait(2);
		pin_prev = pin_o;
		cyc_wait(2);
		chk1(pin_o, ~pin_prev, "osc out while stopped");
		wr(4'hD, 8'h01);
		cyc_wait(2);
		pin_prev = pin_o;
		cyc_wait(4);
		chk1(pin_o, ~pin_prev, "half rate out while stopped");
		wr(4'hD, 8'h02);
		rd(4'hD, 8'h02);
		pin_prev = pin_o;
		cyc_wait(8);
		chk1(pin_o, ~pin_prev, "quarter rate out while stopped");
		wr(4'h0, 8'h80);
		cyc_wait(1);
		chk1(pin_oe, 1'b0, "pin released");
		wr(4'h0, 8'hA0);
		n0 = n_tick;
		u_rip_host_model.pulses(40);
		chk8(8'(n_tick - n0), 8'h00, "tick while stopped");
		wr(4'h0, 8'h80);
		u_rip_host_model.pulses(31);
		chk8(8'(n_tick - n0), 8'h00, "early tick");
		u_rip_host_model.pulses(1);
		chk8(8'(n_tick - n0), 8'h01, "first tick");
		u_rip_host_model.pulses(63);
		chk8(8'(n_tick - n0), 8'h01, "early second tick");
		u_rip_host_model.pulses(1);
		chk8(8'(n_tick - n0), 8'h02, "second tick");
		summarize();
	end

	// Cuts a hang short; the sequence needs about 32k clocks.
	initial begin
		repeat (90000) @(posedge ref_clk);
		n_errors++;
		summarize();
	end
endmodule : rip_ctrl_tb

bind rip_ctrl rip_ctrl_properties u_rip_ctrl_properties (
	.ref_clk            (ref_clk),
	.reset_n            (reset_n),
	.bus_req            (bus_req),
	.bus_rdata          (bus_rdata),
	.minute_event       (minute_event),
	.countdown_event    (countdown_event),
	.alarm_event        (alarm_event),
	.clock_output_pin_oe(clock_output_pin_oe),
	.int_n_o            (int_n_o),
	.int_n_oe           (int_n_oe),
	.time_tick          (time_tick)
);
